//--- uart_interrupt_flag_bank.sv
// Purpose: event flag, force, clear and enable registers of a low-energy serial port
// Assumes: event strobes (one cycle wide) and buffer states (held levels) arrive from logic on i_clk_sys
// Notes: registers sit on an Avalon-MM slave with waitrequest; each access takes two cycles
`timescale 1ns/1ns

// Contract
// RULE_01: signal-frame flag, bit 10, resets low, sets on a detected signal frame.
// RULE_02: start-frame flag, bit 9, resets low, sets on a detected start frame.
// RULE_03: multiprocessor address flag, bit 8, resets low, sets on an address frame.
// RULE_04: framing-error flag, bit 7, sets on a framing error only without receive blocking.
// RULE_05: parity-error flag, bit 6, sets on a parity error only without receive blocking.
// RULE_06: write into a full transmit buffer sets bit 5 and is discarded.
// RULE_07: reading an empty receive buffer sets the underflow flag, bit 4.
// RULE_08: frame arriving with full shift register sets bit 3; new frame overwrites.
// RULE_09: receive-valid flag, bit 2, resets low, sets when receive data appear.
// RULE_10: transmit-space flag, bit 1, resets high, sets when buffer space appears.
// RULE_11: transmit-complete flag, bit 0, resets low, sets when buffer and shifter empty.
// RULE_12: flag register at 0x02C is read-only; bits 31 to 11 read zero.
// RULE_13: writing one to force bits 10..3 or 0 at 0x030 sets that flag.
// RULE_14: software writes zero to force bits 2:1 and 31:11; those cannot force.
// RULE_15: clear register at 0x034 clears each flag written with one; the code clears only bits 10..3 and 0 this way, bits 2:1 ignore it.
// RULE_16: enable register at 0x038 selects which set flags raise the interrupt.
// RULE_17: zero bits in the force register change nothing; it reads back zero.
module uart_interrupt_flag_bank (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // avalon-mm slave
    input wire logic [uart_flag_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [uart_flag_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [uart_flag_pkg::BE_W-1:0] i_avs_byteenable,
    output logic [uart_flag_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // receiver events
    input wire logic i_rx_signal_frame,
    input wire logic i_rx_start_frame,
    input wire logic i_rx_multiproc_addr,
    input wire logic i_rx_framing_error,
    input wire logic i_rx_parity_error,
    input wire logic i_rx_blocking,
    input wire logic i_rx_frame_done,
    input wire logic i_rx_shift_full,
    input wire logic i_rx_data_ready,
    input wire logic i_rx_valid_drop,
    input wire logic i_rx_read,
    input wire logic i_rx_buf_empty,
    // transmitter events
    input wire logic i_tx_write,
    input wire logic i_tx_buf_full,
    input wire logic i_tx_space_ready,
    input wire logic i_tx_space_drop,
    input wire logic i_tx_idle,
    // results
    output logic o_tx_write_accept,
    output logic o_rx_shift_overwrite,
    output logic [uart_flag_pkg::FLAG_W-1:0] o_event_flags,
    output logic o_irq
);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus_state;
        logic waitreq;
        logic [uart_flag_pkg::DATA_W-1:0] rdata;
        logic [uart_flag_pkg::FLAG_W-1:0] enable;
        logic irq;
        logic tx_accept;
        logic rx_overwrite;
        logic tx_idle_prev;
    } main_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // expands byte enables into a bit mask over the 32-bit word
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : lane_mask

    // low flag field of a written word, gated by byte enables
    function automatic logic [10:0] flag_field(input logic [31:0] data, input logic [3:0] be);
        logic [31:0] w;
        w = data & lane_mask(be);
        return w[10:0];
    endfunction : flag_field

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    main_state_t state_reg;
    main_state_t state_next;
    logic [uart_flag_pkg::FLAG_W-1:0] flags;
    logic [uart_flag_pkg::FLAG_W-1:0] hw_set;
    logic [uart_flag_pkg::FLAG_W-1:0] hw_clr;
    logic [uart_flag_pkg::FLAG_W-1:0] sw_set;
    logic [uart_flag_pkg::FLAG_W-1:0] sw_clr;
    logic [uart_flag_pkg::FLAG_W-1:0] wr_field;
    logic wr_commit;
    logic tx_done_rise;

    // ------------------------------------------------------------
    // hardware event mapping
    // ------------------------------------------------------------
    // transmit complete is taken on the rising edge of idle so a
    // software clear is not undone while the line simply stays idle
    assign tx_done_rise = i_tx_idle & ~state_reg.tx_idle_prev;

    always_comb begin
        hw_set = '0;
        hw_set[uart_flag_pkg::BIT_SIGNAL_FRAME] = i_rx_signal_frame; // RULE_01
        hw_set[uart_flag_pkg::BIT_START_FRAME] = i_rx_start_frame; // RULE_02
        hw_set[uart_flag_pkg::BIT_MULTIPROC_ADDR] = i_rx_multiproc_addr; // RULE_03
        hw_set[uart_flag_pkg::BIT_FRAMING_ERROR] = i_rx_framing_error & ~i_rx_blocking; // RULE_04
        hw_set[uart_flag_pkg::BIT_PARITY_ERROR] = i_rx_parity_error & ~i_rx_blocking; // RULE_05
        hw_set[uart_flag_pkg::BIT_TX_OVERFLOW] = i_tx_write & i_tx_buf_full; // RULE_06
        hw_set[uart_flag_pkg::BIT_RX_UNDERFLOW] = i_rx_read & i_rx_buf_empty; // RULE_07
        hw_set[uart_flag_pkg::BIT_RX_OVERFLOW] = i_rx_frame_done & i_rx_shift_full; // RULE_08
        hw_set[uart_flag_pkg::BIT_RX_VALID] = i_rx_data_ready; // RULE_09
        hw_set[uart_flag_pkg::BIT_TX_SPACE] = i_tx_space_ready; // RULE_10
        hw_set[uart_flag_pkg::BIT_TX_COMPLETE] = tx_done_rise; // RULE_11
    end

    // buffer-level flags follow the buffers; software cannot touch them
    always_comb begin
        hw_clr = '0;
        hw_clr[uart_flag_pkg::BIT_RX_VALID] = i_rx_valid_drop;
        hw_clr[uart_flag_pkg::BIT_TX_SPACE] = i_tx_space_drop;
    end

    // ------------------------------------------------------------
    // software force and clear
    // ------------------------------------------------------------
    // writes take effect only at the edge where waitrequest is low
    assign wr_commit = (state_reg.bus_state == BUS_ACK) & i_avs_write & ~i_avs_read;
    assign wr_field = flag_field(i_avs_writedata, i_avs_byteenable);

    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (wr_commit && i_avs_address == uart_flag_pkg::OFS_EVENT_FLAGS_FORCE) begin
            // zero bits and bits 2:1 are ignored
            sw_set = wr_field & uart_flag_pkg::SW_ACCESS_MASK; // RULE_13 RULE_14 RULE_17
        end
        if (wr_commit && i_avs_address == uart_flag_pkg::OFS_EVENT_FLAGS_CLEAR) begin
            sw_clr = wr_field & uart_flag_pkg::SW_ACCESS_MASK; // RULE_15
        end
    end

    // ------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------
    sticky_flag_bank #(
        .WIDTH(uart_flag_pkg::FLAG_W),
        .RESET_VALUE(uart_flag_pkg::EVENT_FLAGS_RESET)
    ) u_flags (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_set(hw_set | sw_set),
        .i_clr(hw_clr | sw_clr),
        .o_flags(flags)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.tx_idle_prev = i_tx_idle;
        // the transmit buffer stores a write only when it had room
        state_next.tx_accept = i_tx_write & ~i_tx_buf_full; // RULE_06
        // tells the receiver that the older shift contents are replaced
        state_next.rx_overwrite = i_rx_frame_done & i_rx_shift_full; // RULE_08
        state_next.irq = |(flags & state_reg.enable); // RULE_16

        case (state_reg.bus_state)
            BUS_IDLE: begin
                state_next.waitreq = 1'b1;
                if (i_avs_read || i_avs_write) begin
                    state_next.bus_state = BUS_ACK;
                    state_next.waitreq = 1'b0;
                    state_next.rdata = uart_flag_pkg::READ_ZERO;
                    if (i_avs_read) begin
                        case (i_avs_address)
                            uart_flag_pkg::OFS_EVENT_FLAGS: begin
                                // upper bits stay zero
                                state_next.rdata = {21'h000000, flags}; // RULE_12
                            end
                            uart_flag_pkg::OFS_EVENT_ENABLE: begin
                                state_next.rdata = {21'h000000, state_reg.enable};
                            end
                            uart_flag_pkg::OFS_EVENT_FLAGS_FORCE: begin
                                state_next.rdata = uart_flag_pkg::READ_ZERO; // RULE_17
                            end
                            default: begin
                                state_next.rdata = uart_flag_pkg::READ_ZERO;
                            end
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                state_next.bus_state = BUS_IDLE;
                state_next.waitreq = 1'b1;
                // writes to the flag register itself are dropped
                if (wr_commit && i_avs_address == uart_flag_pkg::OFS_EVENT_ENABLE) begin
                    state_next.enable = wr_field; // RULE_16
                end
            end
            default: begin
                state_next.bus_state = BUS_IDLE;
                state_next.waitreq = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_reg.bus_state <= BUS_IDLE;
            state_reg.waitreq <= 1'b1;
            state_reg.rdata <= uart_flag_pkg::READ_ZERO;
            state_reg.enable <= uart_flag_pkg::EVENT_ENABLE_RESET;
            state_reg.irq <= 1'b0;
            state_reg.tx_accept <= 1'b0;
            state_reg.rx_overwrite <= 1'b0;
            state_reg.tx_idle_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_avs_readdata = state_reg.rdata;
    assign o_avs_waitrequest = state_reg.waitreq;
    assign o_tx_write_accept = state_reg.tx_accept;
    assign o_rx_shift_overwrite = state_reg.rx_overwrite;
    assign o_event_flags = flags;
    assign o_irq = state_reg.irq;

endmodule : uart_interrupt_flag_bank

//--- uart_flag_pkg.sv
// Purpose: shared constants for the serial port event flag bank
// Assumes: 32-bit register bus with byte addresses, one word per register
// Notes: flag positions are common to the flag, force, clear and enable registers
package uart_flag_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned FLAG_W = 11;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h2C;
    localparam logic [7:0] OFS_EVENT_FLAGS_FORCE = 8'h30;
    localparam logic [7:0] OFS_EVENT_FLAGS_CLEAR = 8'h34;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h38;

    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_SIGNAL_FRAME = 10;
    localparam int unsigned BIT_START_FRAME = 9;
    localparam int unsigned BIT_MULTIPROC_ADDR = 8;
    localparam int unsigned BIT_FRAMING_ERROR = 7;
    localparam int unsigned BIT_PARITY_ERROR = 6;
    localparam int unsigned BIT_TX_OVERFLOW = 5;
    localparam int unsigned BIT_RX_UNDERFLOW = 4;
    localparam int unsigned BIT_RX_OVERFLOW = 3;
    localparam int unsigned BIT_RX_VALID = 2;
    localparam int unsigned BIT_TX_SPACE = 1;
    localparam int unsigned BIT_TX_COMPLETE = 0;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    // only the transmit space flag comes out of reset set
    localparam logic [10:0] EVENT_FLAGS_RESET = 11'h002;
    localparam logic [10:0] EVENT_ENABLE_RESET = 11'h000;
    // bits that software may force or clear: 10..3 and 0
    localparam logic [10:0] SW_ACCESS_MASK = 11'h7F9;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : uart_flag_pkg

//--- sticky_flag_bank.sv
// Purpose: bank of sticky flags with per-bit set and clear strobes
// Assumes: set and clear strobes come from logic on the same clock
// Notes: a set in the same cycle as a clear wins, so no event is lost
`timescale 1ns/1ns
module sticky_flag_bank #(
    parameter int unsigned WIDTH = 11,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // strobes
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_clr,
    // state
    output logic [WIDTH-1:0] o_flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;

    always_comb begin
        state_next = state_reg;
        // set is or-ed in after the clear so it takes priority
        state_next.flags = (state_reg.flags & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_reg.flags <= RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_flags = state_reg.flags;

endmodule : sticky_flag_bank

//--- uart_interrupt_flag_bank_checker.sv
// Purpose: assertions on the serial port event flag bank ports
// Assumes: every signal lives on i_clk_sys; reset is synchronous, active high
// Notes: a write completing in the same cycle may force flags, so negative checks exclude it
`timescale 1ns/1ns
module uart_interrupt_flag_bank_checker (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // bus
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic [uart_flag_pkg::DATA_W-1:0] o_avs_readdata,
    // events
    input wire logic i_rx_signal_frame,
    input wire logic i_rx_framing_error,
    input wire logic i_rx_parity_error,
    input wire logic i_rx_blocking,
    input wire logic i_rx_frame_done,
    input wire logic i_rx_shift_full,
    input wire logic i_rx_read,
    input wire logic i_rx_buf_empty,
    input wire logic i_tx_write,
    input wire logic i_tx_buf_full,
    input wire logic i_tx_idle,
    // results
    input wire logic o_tx_write_accept,
    input wire logic o_rx_shift_overwrite,
    input wire logic [uart_flag_pkg::FLAG_W-1:0] o_event_flags
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    property p_sig; i_rx_signal_frame |=> o_event_flags[10]; endproperty
    a_sig: assert property (p_sig) else $error("signal frame flag missed");
    property p_framing_error_flag; i_rx_framing_error && !i_rx_blocking |=> o_event_flags[7]; endproperty
    a_framing_error_flag: assert property (p_framing_error_flag) else $error("framing error flag missed");
    property p_parity_error_flag; i_rx_parity_error && i_rx_blocking && !o_event_flags[6] && !(i_avs_write && !o_avs_waitrequest)
        |=> !o_event_flags[6]; endproperty
    a_parity_error_flag: assert property (p_parity_error_flag) else $error("parity flag set while blocked");
    property p_tx_overflow_flag; i_tx_write && i_tx_buf_full |=> o_event_flags[5] && !o_tx_write_accept; endproperty
    a_tx_overflow_flag: assert property (p_tx_overflow_flag) else $error("tx overflow not handled");
    property p_rx_underflow_flag; i_rx_read && i_rx_buf_empty |=> o_event_flags[4]; endproperty
    a_rx_underflow_flag: assert property (p_rx_underflow_flag) else $error("rx underflow flag missed");
    property p_rx_overflow_flag; i_rx_frame_done && i_rx_shift_full |=> o_event_flags[3] && o_rx_shift_overwrite; endproperty
    a_rx_overflow_flag: assert property (p_rx_overflow_flag) else $error("rx overflow not handled");
    // an idle edge seen across the reset release is not a finished transmission
    property p_txc; $rose(i_tx_idle) && !$past(i_sys_rst) |=> o_event_flags[0]; endproperty
    a_txc: assert property (p_txc) else $error("tx complete flag missed");
    property p_rsvd; !o_avs_waitrequest |-> o_avs_readdata[31:11] == 21'h000000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read bits set");
    c_tx_overflow_flag: cover property (i_tx_write && i_tx_buf_full);
    c_block: cover property (i_rx_framing_error && i_rx_blocking);
    c_read: cover property (!o_avs_waitrequest && !i_avs_write);
endmodule : uart_interrupt_flag_bank_checker

bind uart_interrupt_flag_bank uart_interrupt_flag_bank_checker checker_u (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .o_avs_readdata(o_avs_readdata), .i_rx_signal_frame(i_rx_signal_frame), .i_rx_framing_error(i_rx_framing_error),
    .i_rx_parity_error(i_rx_parity_error), .i_rx_blocking(i_rx_blocking), .i_rx_frame_done(i_rx_frame_done),
    .i_rx_shift_full(i_rx_shift_full), .i_rx_read(i_rx_read), .i_rx_buf_empty(i_rx_buf_empty),
    .i_tx_write(i_tx_write), .i_tx_buf_full(i_tx_buf_full), .i_tx_idle(i_tx_idle),
    .o_tx_write_accept(o_tx_write_accept), .o_rx_shift_overwrite(o_rx_shift_overwrite),
    .o_event_flags(o_event_flags));

//--- uart_interrupt_flag_bank_bench.sv
// Purpose: self-checking bench for the serial port event flag bank
// Assumes: bench is bus master and event source on one 20 MHz clock
// Notes: strobes packed in ev, levels in lv, so the event scenario is a table
`timescale 1ns/1ns
module uart_interrupt_flag_bank_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic wreq;
    // 0 sig 1 start 2 addr 3 framing_error_flag 4 parity_error_flag 5 frame 6 valid 7 vdrop 8 rxrd 9 txwr 10 space 11 sdrop
    logic [11:0] ev = 12'h000;
    // 0 blocking 1 shift full 2 rx empty 3 tx full 4 tx idle
    logic [4:0] lv = 5'h00;
    logic acc;
    logic ovw;
    logic [10:0] flags;
    logic irq;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [11:0] EV_P [10] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020, 12'h100, 12'h200,
        12'h000, 12'h040};
    // receive valid comes last: nothing in the loop drops it, so it stays set until the final fire
    localparam logic [4:0] EV_L [10] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
    localparam logic [10:0] EV_F [10] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h008, 11'h010, 11'h020,
        11'h001, 11'h004};
    always #25 clk = ~clk;
    uart_interrupt_flag_bank dut_u (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_rx_signal_frame(ev[0]), .i_rx_start_frame(ev[1]), .i_rx_multiproc_addr(ev[2]),
        .i_rx_framing_error(ev[3]), .i_rx_parity_error(ev[4]), .i_rx_blocking(lv[0]), .i_rx_frame_done(ev[5]),
        .i_rx_shift_full(lv[1]), .i_rx_data_ready(ev[6]), .i_rx_valid_drop(ev[7]), .i_rx_read(ev[8]),
        .i_rx_buf_empty(lv[2]), .i_tx_write(ev[9]), .i_tx_buf_full(lv[3]), .i_tx_space_ready(ev[10]),
        .i_tx_space_drop(ev[11]), .i_tx_idle(lv[4]), .o_tx_write_accept(acc), .o_rx_shift_overwrite(ovw),
        .o_event_flags(flags), .o_irq(irq));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // request held until the edge that sees waitrequest low; data taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= ~w;
        wr <= w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp, what);
    endtask : rreg
    task automatic fire(input logic [11:0] p, input logic [4:0] l);
        @(posedge clk);
        ev <= p;
        lv <= l;
        @(posedge clk);
        ev <= 12'h000;
        @(negedge clk);
    endtask : fire
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rreg(8'h2C, 32'h0000_0002, "flags at reset");
        rreg(8'h38, 32'h0000_0000, "enable at reset");
        rreg(8'h30, 32'h0000_0000, "force reads zero");
        wreg(8'h2C, 32'h0000_07FD);
        rreg(8'h2C, 32'h0000_0002, "flags read-only");
        rreg(8'h3C, 32'h0000_0000, "unmapped read");
        $display("test reset done");
    endtask : t_reset
    task automatic t_events();
        for (int i = 0; i < 10; i++) begin
            fire(EV_P[i], EV_L[i]);
            check(32'(flags), 32'(EV_F[i] | 11'h002), "event flag");
            check(32'({acc, ovw}), 32'({1'b0, i == 5}), "strobe result");
            wreg(8'h34, 32'h0000_07F9);
            @(negedge clk);
            check(32'(flags), 32'(11'h002 | (EV_F[i] & 11'h004)), "flag clear");
        end
        fire(12'h3A0, 5'h00);
        check(32'({flags, acc, ovw}), 32'({11'h002, 2'b10}), "no fault");
        $display("test events done");
    endtask : t_events
    task automatic t_block();
        fire(12'h018, 5'h01);
        check(32'(flags), 32'h0000_0002, "errors while blocked");
        $display("test blocking done");
    endtask : t_block
    task automatic t_force();
        logic [10:0] exp;
        exp = 11'h000;
        fire(12'h800, 5'h00);
        for (int b = 0; b < 11; b++) begin
            if (b == 1 || b == 2) continue;
            exp[b] = 1'b1;
            wreg(8'h30, 32'h0000_0001 << b);
            @(negedge clk);
            check(32'(flags), 32'(exp), "forced flag");
        end
        rreg(8'h2C, 32'h0000_07F9, "flag read");
        rreg(8'h30, 32'h0000_0000, "force read");
        wreg(8'h34, 32'h0000_07F9);
        fire(12'h400, 5'h00);
        check(32'(flags), 32'h0000_0002, "space returns");
        $display("test force done");
    endtask : t_force
    task automatic t_irq();
        wreg(8'h38, 32'h0000_0400);
        rreg(8'h38, 32'h0000_0400, "enable readback");
        wreg(8'h30, 32'h0000_0200);
        repeat (2) @(negedge clk);
        check(32'(irq), 32'h0000_0000, "masked flag");
        wreg(8'h30, 32'h0000_0400);
        repeat (2) @(negedge clk);
        check(32'(irq), 32'h0000_0001, "enabled flag");
        wreg(8'h34, 32'h0000_07F9);
        repeat (2) @(negedge clk);
        check(32'(irq), 32'h0000_0000, "cleared flag");
        $display("test irq done");
    endtask : t_irq
    // ------------------------------------------------------------
    // sequence and timeout
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_events();
        t_block();
        t_force();
        t_irq();
        give_verdict();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            give_verdict();
        end
    end
endmodule : uart_interrupt_flag_bank_bench
